/* rtl/gmj_demapper.sv */
// module: gmp de-mapper end, rebuilds counts and gates buffer writes
module gmj_demapper
   import gmj_pkg::*;
#(
   parameter int M = 1,                     // bytes per entity group
   parameter logic [GMJ_CNT_W-1:0] P_SERVER = 16'h3B80  // payload capacity
) (
   // link from mapper
   gmj_if.demapper lnk,
   // mode selection
   input wire logic bit_gran,               // 1: n=1, 0: n=8
   input wire logic odtuc_mode,             // 1: 128 x M entity size
   // client side
   output logic cli_valid,
   output logic [GMJ_DAT_W-1:0] cli_data,
   output logic [GMJ_CNT_W-1:0] cn_rec,     // rebuilt n-bit count
   output logic cli_clk_en                  // client pacing enable
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      gmj_cnt_t cm;          // received m-bit count
      gmj_cnt_t cn;          // rebuilt n-bit count
      gmj_cnt_t phase;       // clock pacing accumulator
      gmj_cnt_t sd;          // sigma-delta accumulator
      logic wv;              // write strobe
      logic [GMJ_DAT_W-1:0] wd; // written word
      logic ce;              // client clock enable
   } gmj_dem_s;
   gmj_dem_s st_r, st_nxt;
   gmj_cnt_t m_over_n;
   logic [GMJ_CNT_W:0] ph_sum;
   logic [GMJ_CNT_W:0] sd_sum;   // accumulator plus recovered count
   logic sd_hit;                 // current field is a data field
   // entity size in n-bit units
   always_comb begin
      m_over_n = gmj_cnt_t'(odtuc_mode ? GMJ_M_FACTOR_ODTUC * M
                                        : GMJ_M_FACTOR_OPU * M);
      if (!bit_gran) begin
         m_over_n = m_over_n / gmj_cnt_t'(GMJ_BITS_PER_BYTE);
      end
   end
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.wv = 1'b0;
      // own sigma-delta decision from the recovered count
      sd_sum = {1'b0, st_r.sd} + {1'b0, st_r.cm};
      sd_hit = (sd_sum >= {1'b0, P_SERVER});
      // take counts from overhead
      if (lnk.oh_valid) begin
         st_nxt.cm = lnk.cm_oh;
         st_nxt.cn = gmj_cnt_t'(m_over_n * lnk.cm_oh) + lnk.cnd_oh;
         st_nxt.sd = GMJ_ACC_RST;
      end else if (lnk.pay_valid) begin
         // step the accumulator once per payload field
         st_nxt.sd = sd_hit ? gmj_cnt_t'(sd_sum - {1'b0, P_SERVER}) : sd_sum[GMJ_CNT_W-1:0];
      end
      // only data positions of the recovered count are written
      if (lnk.pay_valid && lnk.pay_data_flag && sd_hit) begin
         st_nxt.wv = 1'b1;
         st_nxt.wd = lnk.pay_data;
      end
      // pace client clock by cn per 2^16 server cycles
      ph_sum = {1'b0, st_r.phase} + {1'b0, st_r.cn};
      st_nxt.phase = ph_sum[GMJ_CNT_W-1:0];
      st_nxt.ce = ph_sum[GMJ_CNT_W];
   end
   // register state
   always_ff @(posedge lnk.ref_clk) begin
      if (lnk.rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign cli_valid = st_r.wv;
   assign cli_data = st_r.wd;
   assign cn_rec = st_r.cn;
   assign cli_clk_en = st_r.ce;
endmodule : gmj_demapper

/* rtl/gmj_fifo.sv */
// module: small synchronous fifo with valid/ready on both sides
module gmj_fifo
   import gmj_pkg::*;
#(
   parameter int WIDTH = GMJ_DAT_W,
   parameter int DEPTH = GMJ_FIFO_DEPTH,
   parameter int PW = GMJ_FIFO_PTR_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [PW:0] level
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PW-1:0] wp;  // write pointer
      logic [PW-1:0] rp;  // read pointer
      logic [PW:0] cnt;   // words held
   } gmj_fifo_s;
   gmj_fifo_s st_r, st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];  // storage words
   logic push, pop;
   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   assign in_ready = (st_r.cnt != DEPTH[PW:0]);
   assign out_valid = (st_r.cnt != '0);
   assign out_data = mem[st_r.rp];
   assign level = st_r.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // next pointers and count
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end
   // register state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // storage write, no reset needed
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[st_r.wp] <= in_data;
      end
   end
endmodule : gmj_fifo

/* rtl/gmj_if.sv */
// interface: server frame link between gmp mapper and de-mapper
interface gmj_if #(
   parameter int DW = 8,
   parameter int CW = 16
) (
   input wire logic ref_clk,
   input wire logic rst
);
   logic frame_start;        // one-cycle pulse at server frame start
   logic oh_valid;           // overhead counts valid, one cycle
   logic [CW-1:0] cm_oh;     // m-bit count carried in overhead
   logic [CW-1:0] cnd_oh;    // accumulated remainder in overhead
   logic pay_valid;          // payload position strobe
   logic pay_data_flag;      // position carries client data
   logic [DW-1:0] pay_data;  // payload word
   // mapper end drives the link
   modport mapper (
      input ref_clk, rst,
      output frame_start, oh_valid, cm_oh, cnd_oh, pay_valid, pay_data_flag, pay_data
   );
   // de-mapper end receives it
   modport demapper (
      input ref_clk, rst,
      input frame_start, oh_valid, cm_oh, cnd_oh, pay_valid, pay_data_flag, pay_data
   );
endinterface : gmj_if

/* rtl/gmj_mapper.sv */
// module: gmp mapper end, counts client n-bit entities and sigma-delta places the client words
// ------------------------------------------------------------------
// Notes on behaviour
// - byte timing granularity is the default
// - single-bit granularity selectable for tight jitter
// - opu/odtuk.ts entity is eight times M
// - odtucn.ts entity is 128 times M
// - count alternates floor/ceiling, fraction kept
// - m-bit count never above payload capacity
// - cm is floor(cn*n/m), remainder cn minus
// - remainders accumulate; overflow adds one to cm
// - cm and remainder sum go to overhead
// - adjusted cm drives sigma-delta distribution
// - count, then overhead, then payload placement
// - client writes continuous; reads follow cm; writes here stall while the buffer is full
// - de-mapper rebuilds cn from overhead counts
// - recovered cm gates receive buffer writes
// - de-mapper paces client clock from cn
// - count adapts toward actual arriving entities
// - buffer fill steers one more/fewer entity
// - keep buffers shallow for low latency
// - count out of range flags rate mismatch
// - field j data when j*cm mod p < cm
// - leftover entities travel only in overhead
// - sigma-delta accumulator cleared each frame start
// ------------------------------------------------------------------
module gmj_mapper
   import gmj_pkg::*;
#(
   parameter int M = 1,                 // bytes per entity group
   parameter logic [GMJ_CNT_W-1:0] P_SERVER = 16'h3B80, // payload capacity
   parameter logic [GMJ_CNT_W-1:0] CN_MIN = 16'h0000,   // steady range low
   parameter logic [GMJ_CNT_W-1:0] CN_MAX = 16'hFFFF    // steady range high
) (
   // link to de-mapper
   gmj_if.mapper lnk,
   // mode selection
   input wire logic bit_gran,           // 1: n=1, 0: n=8
   input wire logic odtuc_mode,         // 1: 128 x M entity size
   // client side
   input wire logic cli_valid,
   output logic cli_ready,
   input wire logic [GMJ_DAT_W-1:0] cli_data,
   input wire logic [GMJ_CNT_W-1:0] cli_bits, // n-bit entities this cycle
   // server timing
   input wire logic srv_frame,          // server frame start pulse
   // status
   output logic rate_err
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      gmj_phase_e ph;        // frame phase
      gmj_cnt_t cn_acc;      // n-bit entities seen this frame
      gmj_cnt_t cn;          // last frame's count
      gmj_cnt_t cm;          // latched m-bit count
      gmj_cnt_t cnd_sum;     // accumulated remainder
      gmj_cnt_t sd_acc;      // sigma-delta accumulator
      gmj_cnt_t pos;         // payload field index
      logic fs;              // frame start out
      logic ohv;             // overhead valid out
      gmj_cnt_t cm_oh;       // overhead m count
      gmj_cnt_t cnd_oh;      // overhead remainder
      logic pv;              // payload strobe out
      logic pd;              // data flag out
      logic [GMJ_DAT_W-1:0] dat; // payload word
      logic err;             // rate mismatch
   } gmj_map_s;
   // registered copy and its next value
   gmj_map_s st_r, st_nxt;
   // ----------------------------------------------------------------
   // buffer and derived sizes
   // ----------------------------------------------------------------
   logic bf_valid, bf_pop;
   logic [GMJ_DAT_W-1:0] bf_data;
   logic [GMJ_FIFO_PTR_W:0] bf_level;
   gmj_cnt_t m_over_n;        // m/n in n-bit entities
   gmj_cnt_t cm_raw, cnd_raw, cm_adj, sd_sum;
   logic [GMJ_CNT_W:0] rem_sum;
   logic is_data;
   logic ref_clk_w, rst_w;    // clock and reset handed to the buffer
   // buffer shares the link clock and its synchronous reset
   assign ref_clk_w = lnk.ref_clk;
   assign rst_w = lnk.rst;
   // client writes into the buffer while it has room; cli_ready drops when full
   gmj_fifo #(.WIDTH(GMJ_DAT_W), .DEPTH(GMJ_FIFO_DEPTH), .PW(GMJ_FIFO_PTR_W)) u_buf (
      .ref_clk(ref_clk_w),
      .rst(rst_w),
      .in_valid(cli_valid),
      .in_ready(cli_ready),
      .in_data(cli_data),
      .out_valid(bf_valid),
      .out_ready(bf_pop),
      .out_data(bf_data),
      .level(bf_level)
   );
   // entity size in n-bit units
   // byte timing divides the bit size by eight
   always_comb begin
      m_over_n = gmj_cnt_t'(odtuc_mode ? GMJ_M_FACTOR_ODTUC * M
                                        : GMJ_M_FACTOR_OPU * M);
      if (!bit_gran) begin
         m_over_n = m_over_n / gmj_cnt_t'(GMJ_BITS_PER_BYTE);
      end                                                        // n=1 keeps bits
   end
   // split the count into m-bit count and remainder
   always_comb begin
      cm_raw = st_r.cn_acc / m_over_n;
      cnd_raw = st_r.cn_acc - gmj_cnt_t'(cm_raw * m_over_n);
      rem_sum = {1'b0, st_r.cnd_sum} + {1'b0, cnd_raw};
      cm_adj = cm_raw;
      // one subtraction suffices: both parts are below m/n
      if (rem_sum >= {1'b0, m_over_n}) begin
         rem_sum = rem_sum - {1'b0, m_over_n};
         cm_adj = cm_raw + 1'b1;
      end
      // fill steering: one more when full-ish, one fewer when low
      if (bf_level >= GMJ_FILL_HI) begin
         cm_adj = cm_adj + 1'b1;
      end else if (bf_level <= GMJ_FILL_LO && cm_adj != '0) begin
         cm_adj = cm_adj - 1'b1;
      end
      // clamp keeps the count inside the payload area
      if (cm_adj > P_SERVER) begin
         cm_adj = P_SERVER;
      end
   end
   // sigma-delta decision for the current field
   assign sd_sum = st_r.sd_acc + st_r.cm;
   // overflow of the accumulator marks a data field
   assign is_data = (sd_sum >= P_SERVER);
   // reads only on data fields, so the count paces the buffer
   assign bf_pop = (st_r.ph == GMJ_PAY) && is_data;
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.fs = 1'b0;
      st_nxt.ohv = 1'b0;
      st_nxt.pv = 1'b0;
      st_nxt.pd = 1'b0;
      // count arriving n-bit entities this frame
      st_nxt.cn_acc = st_r.cn_acc + cli_bits;
      case (st_r.ph)
         GMJ_IDLE: begin
            // wait for the next server frame
            if (srv_frame) begin
               st_nxt.ph = GMJ_OH;
            end
         end
         GMJ_OH: begin
            // count known, now emit overhead before payload
            st_nxt.cn = st_r.cn_acc;
            st_nxt.cn_acc = cli_bits;
            st_nxt.cm = cm_adj;
            st_nxt.cnd_sum = rem_sum[GMJ_CNT_W-1:0];
            st_nxt.cm_oh = cm_adj;
            st_nxt.cnd_oh = rem_sum[GMJ_CNT_W-1:0];
            st_nxt.err = (st_r.cn_acc < CN_MIN) || (st_r.cn_acc > CN_MAX);
            st_nxt.fs = 1'b1;
            st_nxt.ohv = 1'b1;
            st_nxt.sd_acc = GMJ_ACC_RST;
            st_nxt.pos = GMJ_POS_RST;
            st_nxt.ph = GMJ_PAY;
         end
         GMJ_PAY: begin
            // one payload field per cycle
            st_nxt.pv = 1'b1;
            // an empty buffer turns a data field into stuff
            st_nxt.pd = is_data && bf_valid;
            st_nxt.dat = bf_data;
            st_nxt.sd_acc = is_data ? sd_sum - P_SERVER : sd_sum;
            st_nxt.pos = st_r.pos + 1'b1;
            // last field returns to idle
            if (st_r.pos == P_SERVER) begin
               st_nxt.ph = GMJ_IDLE;
            end
            // a new frame cuts the payload short
            if (srv_frame) begin
               st_nxt.ph = GMJ_OH;
            end
         end
         default: begin
            // unknown phase falls back to idle
            st_nxt.ph = GMJ_IDLE;
         end
      endcase
   end
   // register state
   // synchronous reset clears every field to zero
   always_ff @(posedge lnk.ref_clk) begin
      if (lnk.rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // outputs straight from flops
   assign lnk.frame_start = st_r.fs;
   assign lnk.oh_valid = st_r.ohv;
   assign lnk.cm_oh = st_r.cm_oh;
   assign lnk.cnd_oh = st_r.cnd_oh;
   assign lnk.pay_valid = st_r.pv;
   assign lnk.pay_data_flag = st_r.pd;
   assign lnk.pay_data = st_r.dat;
   assign rate_err = st_r.err;
endmodule : gmj_mapper

/* rtl/gmj_pkg.sv */
// package: shared constants and types for the gmp justifier ends
package gmj_pkg;
   // ----------------------------------------------------------------
   // sizing
   // ----------------------------------------------------------------
   localparam int GMJ_CNT_W = 16;              // width of count fields
   localparam int GMJ_DAT_W = 8;               // width of one client word
   localparam int GMJ_FIFO_DEPTH = 4;          // words in the data fifo
   localparam int GMJ_FIFO_PTR_W = 2;          // pointer width for that depth
   localparam int GMJ_BITS_PER_BYTE = 8;       // bits in one byte
   localparam int GMJ_M_FACTOR_OPU = 8;        // m = 8 x M for opu / odtuk.ts
   localparam int GMJ_M_FACTOR_ODTUC = 128;    // m = 128 x M for odtucn.ts
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [GMJ_CNT_W-1:0] GMJ_CNT_RST = 16'h0000;
   localparam logic [GMJ_CNT_W-1:0] GMJ_ACC_RST = 16'h0000;
   localparam logic [GMJ_CNT_W-1:0] GMJ_POS_RST = 16'h0001;
   // fill thresholds for the buffer steering
   localparam logic [GMJ_FIFO_PTR_W:0] GMJ_FILL_HI = 3'h3;
   localparam logic [GMJ_FIFO_PTR_W:0] GMJ_FILL_LO = 3'h1;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef logic [GMJ_CNT_W-1:0] gmj_cnt_t;   // generic count
   typedef enum logic [1:0] {GMJ_IDLE, GMJ_OH, GMJ_PAY} gmj_phase_e;
endpackage : gmj_pkg

/* tb/generic_mapping_procedure_justifier_tb_top.sv */
// testbench: both gmp ends joined over the link, random and corner frames
module generic_mapping_procedure_justifier_tb_top
   import gmj_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam logic [15:0] PS = 16'h0040;    // payload fields per frame
   localparam logic [15:0] CMIN = 16'h0010;  // steady range low
   localparam logic [15:0] CMAX = 16'h1000;  // steady range high
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic bit_gran = 1'b0;
   logic odtuc_mode = 1'b0;
   logic cli_valid = 1'b0;
   logic cli_ready;
   logic [7:0] cli_data = 8'h00;
   logic [15:0] cli_bits = 16'h0000;
   logic srv_frame = 1'b0;
   logic rate_err;
   logic dm_valid;
   logic [7:0] dm_data;
   logic [15:0] cn_rec;
   logic dm_ce;                   // paced client enable
   logic [15:0] lfsr = 16'h0042;  // random source
   logic [15:0] sig;              // expected remainder sum
   logic [15:0] cn_prev;          // count sent last frame
   logic took = 1'b0;             // last offer accepted
   logic pend = 1'b0;             // data field seen last cycle
   logic [7:0] pend_d;            // its word
   logic [7:0] sent[$];           // accepted client words
   int flood = 0;                 // 0 random, 1 always, 2 stall
   int refused = 0;
   int fails = 0;
   int check_count = 0;
   always #10 ref_clk = ~ref_clk;
   gmj_if #(.DW(8), .CW(16)) u_gmj_if (.ref_clk(ref_clk), .rst(rst));
   gmj_mapper #(.M(1), .P_SERVER(PS), .CN_MIN(CMIN), .CN_MAX(CMAX)) u_gmj_mapper (
      .lnk(u_gmj_if.mapper), .bit_gran(bit_gran), .odtuc_mode(odtuc_mode),
      .cli_valid(cli_valid), .cli_ready(cli_ready), .cli_data(cli_data),
      .cli_bits(cli_bits), .srv_frame(srv_frame), .rate_err(rate_err));
   gmj_demapper #(.M(1), .P_SERVER(PS)) u_gmj_demapper (.lnk(u_gmj_if.demapper),
      .bit_gran(bit_gran), .odtuc_mode(odtuc_mode), .cli_valid(dm_valid), .cli_data(dm_data),
      .cn_rec(cn_rec), .cli_clk_en(dm_ce));
   gmj_chk #(.P_SERVER(PS)) u_gmj_chk (.ref_clk(ref_clk), .rst(rst),
      .frame_start(u_gmj_if.frame_start), .oh_valid(u_gmj_if.oh_valid),
      .cm_oh(u_gmj_if.cm_oh), .cnd_oh(u_gmj_if.cnd_oh), .pay_valid(u_gmj_if.pay_valid),
      .pay_data_flag(u_gmj_if.pay_data_flag), .pay_data(u_gmj_if.pay_data));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[14] ^ v[12] ^ v[3]};
   endfunction : nxt
   // m over n for M of one
   function automatic logic [15:0] ratio(input logic b, input logic o);
      return (o ? 16'h0080 : 16'h0008) >> (b ? 0 : 3);
   endfunction : ratio
   task automatic chk(input bit ok, input string msg);
      check_count++;
      if (!ok) begin
         fails++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   // client offers held until taken
   always @(posedge ref_clk) begin
      took = cli_valid && cli_ready;
      if (rst) begin
         sent.delete();
      end else if (took) begin
         sent.push_back(cli_data);
      end
      if (cli_valid && !cli_ready) begin
         refused++;
      end
   end
   always @(negedge ref_clk) begin
      lfsr = nxt(lfsr);
      if (!cli_valid || took) begin
         cli_valid = !rst && (flood == 1 || (flood == 0 && lfsr[0]));
         cli_data = lfsr[15:8];
      end
      if (!rst && pend) begin
         chk(dm_valid === 1'b1 && dm_data === pend_d, "de-mapper write");
      end else if (!rst) begin
         chk(dm_valid === 1'b0, "stray de-mapper write");
      end
      pend = !rst && u_gmj_if.pay_valid === 1'b1 && u_gmj_if.pay_data_flag === 1'b1;
      pend_d = u_gmj_if.pay_data;
      if (pend) begin
         chk(sent.size() > 0 && u_gmj_if.pay_data === sent.pop_front(), "payload order");
      end
   end
   // one server frame: overhead checks, then payload count
   task automatic frame(input int f);
      logic [15:0] mn;
      logic [15:0] base;
      logic [15:0] cn;
      int k;
      int npay;
      int pulses;
      int lo;
      logic [15:0] rb;
      mn = ratio(bit_gran, odtuc_mode);
      cn = (f == 0) ? mn * PS : (f == 2) ? 16'h0000 : mn * {10'h000, lfsr[5:0]} + lfsr[15:8] % mn;
      srv_frame = 1'b1;
      @(negedge ref_clk);
      srv_frame = 1'b0;
      k = 0;
      while (u_gmj_if.oh_valid !== 1'b1 && k < 8) begin
         @(negedge ref_clk);
         k++;
      end
      chk(k < 8, "no overhead");
      if (k >= 8) begin
         close_out();
      end
      base = cn_prev / mn;
      sig = sig + cn_prev - base * mn;
      if (sig >= mn) begin
         sig = sig - mn;
         base = base + 16'h0001;
      end
      chk(u_gmj_if.cnd_oh === sig, "remainder sum");
      chk(u_gmj_if.cm_oh + 16'h0001 >= base && u_gmj_if.cm_oh <= base + 16'h0001, "count");
      @(negedge ref_clk);
      rb = mn * u_gmj_if.cm_oh + u_gmj_if.cnd_oh;
      lo = (70 * int'(rb)) / 65536;
      pulses = 0;
      chk(cn_rec === rb, "rebuilt count");
      chk(rate_err === (cn_prev < CMIN || cn_prev > CMAX), "rate flag");
      cli_bits = cn;
      cn_prev = cn;
      npay = (u_gmj_if.pay_valid === 1'b1) ? 1 : 0;
      @(negedge ref_clk);
      cli_bits = 16'h0000;
      for (k = 0; k < 70; k++) begin
         npay += (u_gmj_if.pay_valid === 1'b1) ? 1 : 0;
         pulses += (dm_ce === 1'b1) ? 1 : 0;
         @(negedge ref_clk);
      end
      chk(npay == PS, "payload fields");
      chk(pulses == lo || pulses == lo + 1, "client pace");
   endtask : frame
   // ----------------------------------------------------------------
   // main sequence: every granularity and entity size
   // ----------------------------------------------------------------
   initial begin
      for (int md = 0; md < 4; md++) begin
         rst = 1'b1;
         bit_gran = md[0];
         odtuc_mode = md[1];
         sig = 16'h0000;
         cn_prev = 16'h0000;
         repeat (8) @(negedge ref_clk);
         rst = 1'b0;
         @(negedge ref_clk);
         for (int f = 0; f < 8; f++) begin
            flood = (f < 3) ? 1 : ((f < 5) ? 2 : 0);
            frame(f);
         end
         $display("mode %0d done, mismatches %0d", md, fails);
      end
      chk(refused > 0, "buffer never refused");
      close_out();
   end
endmodule : generic_mapping_procedure_justifier_tb_top

/* tb/gmj_chk.sv */
// checker: concurrent assertions on the mapper to de-mapper link
module gmj_chk
   import gmj_pkg::*;
#(
   parameter logic [GMJ_CNT_W-1:0] P_SERVER = 16'h0040  // payload fields per frame
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link signals
   input wire logic frame_start,
   input wire logic oh_valid,
   input wire logic [15:0] cm_oh,
   input wire logic [15:0] cnd_oh,
   input wire logic pay_valid,
   input wire logic pay_data_flag,
   input wire logic [7:0] pay_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // reference sigma-delta model
   // ----------------------------------------------------------------
   logic [16:0] acc_r;   // overflow accumulator
   logic [16:0] sum_w;   // accumulator plus count
   logic [15:0] pos_r;   // payload fields seen
   logic [15:0] dcnt_r;  // data fields seen
   assign sum_w = acc_r + {1'b0, cm_oh};
   // cleared at each overhead, stepped per field
   always_ff @(posedge ref_clk) begin
      if (rst || oh_valid) begin
         acc_r <= 17'h00000;
         pos_r <= 16'h0000;
         dcnt_r <= 16'h0000;
      end else if (pay_valid) begin
         acc_r <= (sum_w >= {1'b0, P_SERVER}) ? sum_w - {1'b0, P_SERVER} : sum_w;
         pos_r <= pos_r + 16'h0001;
         dcnt_r <= dcnt_r + {15'h0000, pay_data_flag};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   data_pattern_a: assert property (pay_data_flag |-> sum_w >= {1'b0, P_SERVER})
      else $error("data field off the sigma-delta pattern");
   cm_cap_a: assert property (oh_valid |-> cm_oh <= P_SERVER)
      else $error("count above payload capacity");
   data_count_a: assert property (pay_data_flag |-> dcnt_r < cm_oh)
      else $error("more data fields than count");
   pay_span_a: assert property (pay_valid |-> pos_r < P_SERVER)
      else $error("too many payload fields");
   oh_frame_a: assert property (oh_valid |-> frame_start)
      else $error("overhead without frame start");
   oh_pulse_a: assert property (oh_valid |=> !oh_valid && !frame_start)
      else $error("overhead pulse too long");
   pay_after_oh_a: assert property (oh_valid |=> pay_valid)
      else $error("payload not after overhead");
   cm_hold_a: assert property (!oh_valid |-> $stable(cm_oh) && $stable(cnd_oh))
      else $error("counts moved inside frame");
   flag_in_pay_a: assert property (pay_data_flag |-> pay_valid)
      else $error("data flag outside payload");
   // main scenarios
   cov_count_c: cover property (oh_valid && cm_oh != 16'h0000);
   cov_stuff_c: cover property (pay_valid && !pay_data_flag);
   cov_burst_c: cover property (pay_data_flag ##1 pay_data_flag);
   cov_data_c: cover property (pay_data_flag && pay_data != 8'h00);
endmodule : gmj_chk
